// [pkg/split_ctr_pkg.sv]
// How it works
// - high down flag sets on limit in updown mode, clears on limit or zero
// - stop with no halt freezes counting, events still fire; resume events clear stop
// - halt freezes counter and blocks all events; halt resets to one
// - while halt is one the stop bit is held at zero
// - one control write may clear halt and set stop together
// - no hardware event clears halt; only a software write does
// - writing the clear bit zeroes the counter; clear bit reads zero
// - updown select zero wraps at limit; one reverses and counts down
// - counter steps at clock divided by prescale plus one, low 12:5, high 28:21
// - mask registers take half writes when split; joined uses low bits only
// - limit clears in one-way mode, reverses direction in updown mode
// - all ones is always a limit, even with no selected event
// - auto limit enable makes a match 0 hit act as a limit
// - limit mask bit n makes event n a limit, low 5:0, high 20:16
// - freeze mask bit n makes event n set halt, low 5:0, high 20:16
// - a counter halted by an event stays halted until software clears it
// - join halves gives one 32-bit counter, else two independent halves
// - resume mask bit n makes event n clear the stop bit, low 5:0, high 20:16
// - pause mask bit n makes event n set the stop bit, low 5:0, high 20:16
package split_ctr_pkg;
   // ------------------------------------------------------------
   // register byte addresses
   // ------------------------------------------------------------
   localparam logic [31:0] CONFIG_ADDR = 32'h5000_4000;
   localparam logic [31:0] CTRL_ADDR   = 32'h5000_4004;
   localparam logic [31:0] LIMIT_ADDR  = 32'h5000_4008;
   localparam logic [31:0] HALT_ADDR   = 32'h5004_400c;
   localparam logic [31:0] PAUSE_ADDR  = 32'h5000_4010;
   localparam logic [31:0] RESUME_ADDR = 32'h5000_4014;
   localparam logic [31:0] COUNT_ADDR  = 32'h5000_4040;
   // ------------------------------------------------------------
   // control field positions, high half adds HALF_OFS
   // ------------------------------------------------------------
   localparam int HALF_OFS  = 16;
   localparam int DOWN_POS  = 0;
   localparam int STOP_POS  = 1;
   localparam int HALT_POS  = 2;
   localparam int CLR_POS   = 3;
   localparam int BIDIR_POS = 4;
   localparam int PRE_POS   = 5;
   localparam int PRE_W     = 8;
   // config bits
   localparam int JOIN_POS   = 0;
   localparam int AUTO_L_POS = 1;
   localparam int AUTO_H_POS = 2;
   // ------------------------------------------------------------
   // widths, masks and reset values
   // ------------------------------------------------------------
   localparam int EV_N   = 6;
   localparam int EV_H_N = 5;
   localparam logic [31:0] EVMASK_FIELDS = 32'h001f_003f;
   localparam logic [31:0] CONFIG_FIELDS = 32'h0000_0007;
   localparam logic [31:0] MASK_RST      = 32'h0000_0000;
   localparam logic [31:0] TOP_FULL      = 32'hffff_ffff;
   localparam logic [31:0] TOP_HALF      = 32'h0000_ffff;
   localparam logic [1:0]  HALT_RST      = 2'h3;
endpackage : split_ctr_pkg

// [pkg/presc_if.sv]
`timescale 1ns/1ps
// link between the control block and one prescale divider
interface presc_if;
   logic [7:0] pre;
   logic       restart;
   logic       run;
   logic       tick;
   modport owner   (output pre, output restart, output run, input tick);
   modport divider (input pre, input restart, input run, output tick);
endinterface : presc_if

// [hw/presc_div.sv]
`timescale 1ns/1ps
module presc_div (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic rst,
   // divider link
   presc_if.divider  p
);
   import split_ctr_pkg::*;

   logic [PRE_W-1:0] div_q;
   logic             tick_q;

   // ------------------------------------------------------------
   // divide by pre plus one, one-cycle tick
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         div_q  <= '0;
         tick_q <= 1'b0;
      end else if (p.restart) begin
         div_q  <= '0;
         tick_q <= 1'b0;
      end else if (p.run) begin
         tick_q <= (div_q == p.pre);
         div_q  <= (div_q == p.pre) ? '0 : div_q + 8'h01;
      end else begin
         tick_q <= 1'b0;
      end
   end

   assign p.tick = tick_q;
endmodule : presc_div

// [hw/split_counter_limit_halt_control.sv]
`timescale 1ns/1ps
module split_counter_limit_halt_control (
   // clock and reset
   input  wire logic                         clk_sys,
   input  wire logic                         rst,
   // register port
   input  wire logic [31:0]                  addr,
   input  wire logic [31:0]                  wr_data,
   input  wire logic                         wr_en,
   input  wire logic [1:0]                   wr_lanes,
   input  wire logic                         rd_en,
   output logic      [31:0]                  rd_data,
   // events and match 0 hits, same clock
   input  wire logic [split_ctr_pkg::EV_N-1:0] event_in,
   input  wire logic                         match0_l,
   input  wire logic                         match0_h,
   // counter state
   output logic      [31:0]                  count_q,
   output logic      [1:0]                   down_flags,
   output logic      [1:0]                   halted
);
   import split_ctr_pkg::*;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [31:0]      cnt_q;
   logic [1:0]       down_q;
   logic [1:0]       stop_q;
   logic [1:0]       halt_q;
   logic [1:0]       bidir_q;
   logic [PRE_W-1:0] pre_q [2];
   logic [31:0]      lim_mask_q;
   logic [31:0]      frz_mask_q;
   logic [31:0]      pause_mask_q;
   logic [31:0]      resume_mask_q;
   logic [31:0]      cfg_q;
   logic [31:0]      rd_data_q;

   // ------------------------------------------------------------
   // functions
   // ------------------------------------------------------------
   // one count step: returns {down_next, count_next}
   function automatic logic [32:0] step_fn(input logic [31:0] cnt, input logic [31:0] top,
                                           input logic down, input logic bidir, input logic lim);
      logic hit;
      hit = lim | (cnt == top);
      if (!down) begin
         if (!hit) begin
            step_fn = {1'b0, (cnt + 32'h1) & top};
         end else if (bidir && (cnt != 32'h0)) begin
            step_fn = {1'b1, cnt - 32'h1};
         end else begin
            step_fn = {1'b0, 32'h0};
         end
      end else if (lim) begin
         step_fn = {1'b0, (cnt + 32'h1) & top};
      end else begin
         step_fn = {(cnt > 32'h1), cnt - 32'h1};     // zero ends the down run
      end
   endfunction : step_fn

   // half-word write merge, reserved bits held at zero
   function automatic logic [31:0] merge_fn(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [1:0] lanes, input logic [31:0] fields);
      logic [31:0] lm;
      lm = {{16{lanes[1]}}, {16{lanes[0]}}};
      merge_fn = ((old & ~lm) | (wd & lm)) & fields;
   endfunction : merge_fn

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   wire cfg_wr    = wr_en && (addr == CONFIG_ADDR);
   wire ctrl_wr   = wr_en && (addr == CTRL_ADDR);
   wire lim_wr    = wr_en && (addr == LIMIT_ADDR);
   wire frz_wr    = wr_en && (addr == HALT_ADDR);
   wire pause_wr  = wr_en && (addr == PAUSE_ADDR);
   wire resume_wr = wr_en && (addr == RESUME_ADDR);

   wire join_h = cfg_q[JOIN_POS];

   // ------------------------------------------------------------
   // event gating and decode
   // ------------------------------------------------------------
   // a halted half sees no events at all; joined mode drops the high masks
   wire [EV_N-1:0]   ev_l = event_in & {EV_N{~halt_q[0]}};
   wire [EV_H_N-1:0] ev_h = event_in[EV_H_N-1:0] & {EV_H_N{~halt_q[1] & ~join_h}};

   wire lim_l = (|(ev_l & lim_mask_q[5:0])) | (cfg_q[AUTO_L_POS] & match0_l);
   wire lim_h = (|(ev_h & lim_mask_q[20:16])) | (cfg_q[AUTO_H_POS] & match0_h & ~join_h);

   wire [1:0] frz;
   wire [1:0] pause;
   wire [1:0] resume;
   assign frz[0]    = |(ev_l & frz_mask_q[5:0]);
   assign frz[1]    = |(ev_h & frz_mask_q[20:16]);
   assign pause[0]  = |(ev_l & pause_mask_q[5:0]);
   assign pause[1]  = |(ev_h & pause_mask_q[20:16]);
   assign resume[0] = |(ev_l & resume_mask_q[5:0]);
   assign resume[1] = |(ev_h & resume_mask_q[20:16]);

   // ------------------------------------------------------------
   // run, clear and prescaler links
   // ------------------------------------------------------------
   wire [1:0] clr;
   wire [1:0] run;
   wire [1:0] tick;
   assign clr[0] = ctrl_wr & wr_data[CLR_POS];
   assign clr[1] = ctrl_wr & wr_data[HALF_OFS+CLR_POS] & ~join_h;
   assign run[0] = ~halt_q[0] & ~stop_q[0];
   assign run[1] = ~halt_q[1] & ~stop_q[1] & ~join_h;

   wire adv_l = tick[0] & run[0];
   wire adv_h = tick[1] & run[1];

   // ------------------------------------------------------------
   // per-half control bits and divider
   // ------------------------------------------------------------
   logic [1:0]       halt_d;
   logic [1:0]       stop_d;
   logic [1:0]       bidir_d;
   logic [PRE_W-1:0] pre_d [2];

   for (genvar i = 0; i < 2; i++) begin : g_half
      presc_if pif ();

      assign pif.pre     = pre_q[i];
      assign pif.restart = clr[i];
      assign pif.run     = run[i];
      assign tick[i]     = pif.tick;

      // halt is set by a write or an event and only a write clears it
      assign halt_d[i] = (ctrl_wr ? wr_data[i*HALF_OFS+HALT_POS] : halt_q[i]) | frz[i];
      // halt forces stop low; pause beats resume and beats a clearing write
      assign stop_d[i] = halt_d[i] ? 1'b0 :
                         pause[i]  ? 1'b1 :
                         resume[i] ? 1'b0 :
                         ctrl_wr   ? wr_data[i*HALF_OFS+STOP_POS] : stop_q[i];
      assign bidir_d[i] = ctrl_wr ? wr_data[i*HALF_OFS+BIDIR_POS] : bidir_q[i];
      assign pre_d[i]   = ctrl_wr ? wr_data[i*HALF_OFS+PRE_POS +: PRE_W] : pre_q[i];

      presc_div u_div (
         .clk_sys (clk_sys),
         .rst     (rst),
         .p       (pif)
      );

      // control bits of one half
      always_ff @(posedge clk_sys or posedge rst) begin
         if (rst) begin
            halt_q[i]  <= HALT_RST[i];
            stop_q[i]  <= 1'b0;
            bidir_q[i] <= 1'b0;
            pre_q[i]   <= '0;
         end else begin
            halt_q[i]  <= halt_d[i];
            stop_q[i]  <= stop_d[i];
            bidir_q[i] <= bidir_d[i];
            pre_q[i]   <= pre_d[i];
         end
      end
   end

   // ------------------------------------------------------------
   // counter next value
   // ------------------------------------------------------------
   wire [32:0] step_u = step_fn(cnt_q, TOP_FULL, down_q[0], bidir_q[0], lim_l);
   wire [32:0] step_l = step_fn({16'h0, cnt_q[15:0]}, TOP_HALF, down_q[0], bidir_q[0], lim_l);
   wire [32:0] step_h = step_fn({16'h0, cnt_q[31:16]}, TOP_HALF, down_q[1], bidir_q[1], lim_h);

   logic [31:0] cnt_d;
   logic [1:0]  down_d;

   // joined halves step as one word under the low controls
   always_comb begin
      cnt_d  = cnt_q;
      down_d = down_q;
      if (clr[0]) begin
         cnt_d[15:0] = 16'h0;
         down_d[0]   = 1'b0;
      end else if (adv_l) begin
         cnt_d[15:0] = join_h ? step_u[15:0] : step_l[15:0];
         down_d[0]   = join_h ? step_u[32]   : step_l[32];
      end
      if (join_h) begin
         down_d[1] = 1'b0;
         if (clr[0]) begin
            cnt_d[31:16] = 16'h0;
         end else if (adv_l) begin
            cnt_d[31:16] = step_u[31:16];
         end
      end else if (clr[1]) begin
         cnt_d[31:16] = 16'h0;
         down_d[1]    = 1'b0;
      end else if (adv_h) begin
         cnt_d[31:16] = step_h[15:0];
         down_d[1]    = step_h[32];
      end
   end

   // counter and direction flags
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cnt_q  <= 32'h0;
         down_q <= 2'h0;
      end else begin
         cnt_q  <= cnt_d;
         down_q <= down_d;
      end
   end

   // ------------------------------------------------------------
   // mask and config registers
   // ------------------------------------------------------------
   // half writes let each half be programmed on its own
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         lim_mask_q    <= MASK_RST;
         frz_mask_q    <= MASK_RST;
         pause_mask_q  <= MASK_RST;
         resume_mask_q <= MASK_RST;
         cfg_q         <= MASK_RST;
      end else begin
         if (lim_wr)    lim_mask_q    <= merge_fn(lim_mask_q, wr_data, wr_lanes, EVMASK_FIELDS);
         if (frz_wr)    frz_mask_q    <= merge_fn(frz_mask_q, wr_data, wr_lanes, EVMASK_FIELDS);
         if (pause_wr)  pause_mask_q  <= merge_fn(pause_mask_q, wr_data, wr_lanes, EVMASK_FIELDS);
         if (resume_wr) resume_mask_q <= merge_fn(resume_mask_q, wr_data, wr_lanes, EVMASK_FIELDS);
         if (cfg_wr)    cfg_q         <= wr_data & CONFIG_FIELDS;
      end
   end

   // ------------------------------------------------------------
   // read back
   // ------------------------------------------------------------
   // clear bits and reserved bits always read zero
   wire [31:0] ctrl_rd = {3'h0, pre_q[1], bidir_q[1], 1'b0, halt_q[1], stop_q[1], down_q[1],
                          3'h0, pre_q[0], bidir_q[0], 1'b0, halt_q[0], stop_q[0], down_q[0]};
   wire [31:0] rd_mux  = (addr == CTRL_ADDR)   ? ctrl_rd       :
                         (addr == LIMIT_ADDR)  ? lim_mask_q    :
                         (addr == HALT_ADDR)   ? frz_mask_q    :
                         (addr == PAUSE_ADDR)  ? pause_mask_q  :
                         (addr == RESUME_ADDR) ? resume_mask_q :
                         (addr == CONFIG_ADDR) ? cfg_q         :
                         (addr == COUNT_ADDR)  ? cnt_q         : 32'h0;

   // read data lives for exactly one cycle
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rd_data_q <= 32'h0;
      end else begin
         rd_data_q <= rd_en ? rd_mux : 32'h0;
      end
   end

   assign rd_data    = rd_data_q;
   assign count_q    = cnt_q;
   assign down_flags = down_q;
   assign halted     = halt_q;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_halt_kept;
      @(posedge clk_sys) disable iff (rst)
      (halt_q[1] && !(ctrl_wr && !wr_data[HALF_OFS+HALT_POS])) |=> halt_q[1];
   endproperty
   a_halt_kept: assert property (p_halt_kept) else $error("high halt cleared without write");

   property p_stop_low_in_halt;
      @(posedge clk_sys) disable iff (rst)
      halt_q[1] |-> !stop_q[1];
   endproperty
   a_stop_low_in_halt: assert property (p_stop_low_in_halt) else $error("stop set while halted");

   property p_halt_frozen;
      @(posedge clk_sys) disable iff (rst)
      (!join_h && halt_q[1] && !clr[1]) |=> $stable(cnt_q[31:16]);
   endproperty
   a_halt_frozen: assert property (p_halt_frozen) else $error("high counter moved in halt");

   property p_stop_frozen;
      @(posedge clk_sys) disable iff (rst)
      (!join_h && stop_q[1] && !clr[1]) |=> (cnt_q[31:16] == $past(cnt_q[31:16]));
   endproperty
   a_stop_frozen: assert property (p_stop_frozen) else $error("high counter moved while stopped");

   property p_clear_zero;
      @(posedge clk_sys) disable iff (rst)
      (ctrl_wr && wr_data[HALF_OFS+CLR_POS] && !join_h) |=> (cnt_q[31:16] == 16'h0) && !down_q[1];
   endproperty
   a_clear_zero: assert property (p_clear_zero) else $error("high clear did not zero counter");

   property p_clear_reads_zero;
      @(posedge clk_sys) disable iff (rst)
      (rd_en && addr == CTRL_ADDR) |=> !rd_data[HALF_OFS+CLR_POS] && !rd_data[CLR_POS];
   endproperty
   a_clear_reads_zero: assert property (p_clear_reads_zero) else $error("clear bit read as one");

   property p_wrap_up;
      @(posedge clk_sys) disable iff (rst)
      (adv_h && !clr[1] && !bidir_q[1] && !down_q[1] && lim_h) |=> (cnt_q[31:16] == 16'h0);
   endproperty
   a_wrap_up: assert property (p_wrap_up) else $error("one-way limit did not wrap");

   property p_ones_reverse;
      @(posedge clk_sys) disable iff (rst)
      (adv_h && !clr[1] && bidir_q[1] && !down_q[1] && cnt_q[31:16] == 16'hffff)
         |=> down_q[1] && (cnt_q[31:16] == 16'hfffe);
   endproperty
   a_ones_reverse: assert property (p_ones_reverse) else $error("all ones did not reverse");

   property p_freeze_sets_halt;
      @(posedge clk_sys) disable iff (rst)
      (|(ev_h & frz_mask_q[20:16])) |=> halt_q[1] ##1 halt_q[1] || $past(ctrl_wr);
   endproperty
   a_freeze_sets_halt: assert property (p_freeze_sets_halt) else $error("freeze event missed");

   property p_resume_clears;
      @(posedge clk_sys) disable iff (rst)
      (resume[1] && !pause[1]) |=> !stop_q[1];
   endproperty
   a_resume_clears: assert property (p_resume_clears) else $error("resume event left stop set");

   property p_ones_wrap;
      @(posedge clk_sys) disable iff (rst)
      (adv_h && !clr[1] && !bidir_q[1] && !down_q[1] && cnt_q[31:16] == 16'hffff)
         |=> (cnt_q[31:16] == 16'h0);
   endproperty
   a_ones_wrap: assert property (p_ones_wrap) else $error("all ones did not wrap in one-way mode");

   property p_pause_sets;
      @(posedge clk_sys) disable iff (rst)
      (pause[1] && !halt_d[1]) |=> stop_q[1];
   endproperty
   a_pause_sets: assert property (p_pause_sets) else $error("pause event left stop clear");

   property p_down_ends_at_zero;
      @(posedge clk_sys) disable iff (rst)
      (adv_h && !clr[1] && down_q[1] && !lim_h && cnt_q[31:16] == 16'h0001)
         |=> !down_q[1] && (cnt_q[31:16] == 16'h0);
   endproperty
   a_down_ends_at_zero: assert property (p_down_ends_at_zero) else $error("down run did not end at zero");

   property p_join_high_flag;
      @(posedge clk_sys) disable iff (rst)
      join_h |=> !down_q[1];
   endproperty
   a_join_high_flag: assert property (p_join_high_flag) else $error("high down flag set while joined");
endmodule : split_counter_limit_halt_control

// [dv/split_counter_limit_halt_control_tb.sv]
`timescale 1ns/1ps
module split_counter_limit_halt_control_tb;
   import split_ctr_pkg::*;
   // ------------------------------------------------------------
   // stimulus and observed signals
   // ------------------------------------------------------------
   logic            clk_sys;
   logic            rst;
   logic [31:0]     addr;
   logic [31:0]     wr_data;
   logic            wr_en;
   logic [1:0]      wr_lanes;
   logic            rd_en;
   logic [31:0]     rd_data;
   logic [EV_N-1:0] event_in;
   logic            match0_l;
   logic            match0_h;
   logic [31:0]     count_q;
   logic [1:0]      down_flags;
   logic [1:0]      halted;
   int              err_count;
   int              n_tests;
   wire  [15:0]     hi = count_q[31:16];

   split_counter_limit_halt_control dut (
      .clk_sys(clk_sys), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .wr_lanes(wr_lanes),
      .rd_en(rd_en), .rd_data(rd_data), .event_in(event_in), .match0_l(match0_l), .match0_h(match0_h),
      .count_q(count_q), .down_flags(down_flags), .halted(halted));

   // free running 200 MHz clock
   always #2.5 clk_sys = ~clk_sys;

   // ------------------------------------------------------------
   // compare, bus and verdict tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_flag(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask : chk_flag

   task automatic conclude;
      if (err_count == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : conclude

   // one-cycle write strobe, returns just after the taking edge
   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] ln);
      @(posedge clk_sys);
      addr     <= a;
      wr_data  <= d;
      wr_lanes <= ln;
      wr_en    <= 1'b1;
      @(posedge clk_sys);
      wr_en    <= 1'b0;
      #1;
   endtask : wr

   // read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
      @(posedge clk_sys);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge clk_sys);
      rd_en <= 1'b0;
      #1;
      chk(rd_data, exp);
   endtask : rd_chk

   task automatic pulse(input logic [EV_N-1:0] ev, input int n);
      @(posedge clk_sys);
      event_in <= ev;
      repeat (n) @(posedge clk_sys);
      event_in <= '0;
      #1;
   endtask : pulse

   // low half stays halted so only the high half moves
   function automatic logic [31:0] ctl(input logic s, h, c, b, input logic [7:0] p);
      return {3'h0, p, b, c, h, s, 1'b0, 16'h0004};
   endfunction : ctl

   task automatic wait_hi(input logic [15:0] v, input int lim);
      int i;
      i = 0;
      while (hi !== v && i < lim) begin
         @(posedge clk_sys);
         #1;
         i++;
      end
      chk({16'h0, hi}, {16'h0, v});
   endtask : wait_hi

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic s_reset;
      chk({30'h0, halted}, 32'h3);
      rd_chk(CTRL_ADDR, 32'h0004_0004);
      rd_chk(LIMIT_ADDR, 32'h0);
      rd_chk(HALT_ADDR, 32'h0);
   endtask : s_reset

   // steady step spacing must be prescale plus one cycles
   task automatic s_rate;
      logic [15:0] v;
      int          gap;
      wr(CTRL_ADDR, ctl(1'b0, 1'b0, 1'b1, 1'b0, 8'h03), 2'h3);
      wait_hi(16'h0001, 20);
      v   = hi;
      gap = 0;
      while (hi === v && gap < 50) begin
         @(posedge clk_sys);
         #1;
         gap++;
      end
      chk(32'(gap), 32'h4);
      chk({16'h0, hi - v}, 32'h1);
      rd_chk(CTRL_ADDR, 32'h0060_0004);
      wr(CTRL_ADDR, ctl(1'b0, 1'b0, 1'b1, 1'b0, 8'h00), 2'h3);
      chk({16'h0, hi}, 32'h0);
   endtask : s_rate

   task automatic s_stop;
      logic [15:0] v;
      wr(CTRL_ADDR, ctl(1'b1, 1'b1, 1'b0, 1'b0, 8'h00), 2'h3);
      rd_chk(CTRL_ADDR, 32'h0004_0004);
      wr(CTRL_ADDR, ctl(1'b1, 1'b0, 1'b0, 1'b0, 8'h00), 2'h3);
      chk({30'h0, halted}, 32'h1);
      v = hi;
      repeat (10) @(posedge clk_sys);
      #1;
      chk({16'h0, hi}, {16'h0, v});
      rd_chk(CTRL_ADDR, 32'h0002_0004);
      wr(RESUME_ADDR, 32'h0004_0000, 2'h3);
      pulse(6'h04, 4);
      repeat (4) @(posedge clk_sys);
      #1;
      chk_flag(hi > v, 1'b1);
      rd_chk(CTRL_ADDR, 32'h0000_0004);
      // a pause event stops the running half again
      wr(PAUSE_ADDR, 32'h0001_0000, 2'h3);
      pulse(6'h01, 1);
      rd_chk(CTRL_ADDR, 32'h0002_0004);
      v = hi;
      repeat (5) @(posedge clk_sys);
      #1;
      chk({16'h0, hi}, {16'h0, v});
      wr(PAUSE_ADDR, 32'h0, 2'h3);
   endtask : s_stop

   // freeze event halts, later events of any kind cannot undo it
   task automatic s_freeze;
      logic [15:0] v;
      wr(HALT_ADDR, 32'h0002_0000, 2'h3);
      pulse(6'h02, 4);
      chk({30'h0, halted}, 32'h3);
      v = hi;
      pulse(6'h3f, 4);
      repeat (4) @(posedge clk_sys);
      #1;
      chk({16'h0, hi}, {16'h0, v});
      chk({30'h0, halted}, 32'h3);
      rd_chk(CTRL_ADDR, 32'h0004_0004);
      wr(HALT_ADDR, 32'h0, 2'h3);
   endtask : s_freeze

   task automatic s_limit;
      wr(LIMIT_ADDR, 32'h0001_0000, 2'h3);
      wr(CTRL_ADDR, ctl(1'b0, 1'b0, 1'b1, 1'b0, 8'h00), 2'h3);
      repeat (20) @(posedge clk_sys);
      pulse(6'h01, 1);
      chk({16'h0, hi}, 32'h0);
      chk_flag(down_flags[1], 1'b0);
   endtask : s_limit

   // joined halves: low controls run one word, low match 0 limits it
   task automatic s_join;
      wr(CONFIG_ADDR, 32'h3, 2'h3);
      wr(CTRL_ADDR, 32'h0004_0018, 2'h3);
      repeat (10) @(posedge clk_sys);
      #1;
      chk(count_q, 32'h9);
      @(posedge clk_sys);
      match0_l <= 1'b1;
      @(posedge clk_sys);
      match0_l <= 1'b0;
      #1;
      chk(count_q, 32'h9);
      chk_flag(down_flags[0], 1'b1);
   endtask : s_join

   task automatic s_auto;
      logic [15:0] v;
      wr(LIMIT_ADDR, 32'h0, 2'h3);
      wr(CONFIG_ADDR, 32'h4, 2'h3);
      wr(CTRL_ADDR, ctl(1'b0, 1'b0, 1'b1, 1'b1, 8'h00), 2'h3);
      repeat (30) @(posedge clk_sys);
      match0_h <= 1'b1;
      @(posedge clk_sys);
      match0_h <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      chk_flag(down_flags[1], 1'b1);
      v = hi;
      @(posedge clk_sys);
      #1;
      chk({16'h0, hi}, {16'h0, v - 16'h1});
      wait_hi(16'h0000, 100);
      repeat (2) @(posedge clk_sys);
      #1;
      chk_flag(down_flags[1], 1'b0);
   endtask : s_auto

   // all ones wraps in one-way mode with no limit event selected
   task automatic s_wrap;
      wr(CONFIG_ADDR, 32'h0, 2'h3);
      wr(CTRL_ADDR, ctl(1'b0, 1'b0, 1'b1, 1'b0, 8'h00), 2'h3);
      wait_hi(16'hffff, 70000);
      @(posedge clk_sys);
      #1;
      chk({16'h0, hi}, 32'h0);
   endtask : s_wrap

   task automatic s_lanes;
      wr(LIMIT_ADDR, 32'hffff_ffff, 2'h1);
      rd_chk(LIMIT_ADDR, 32'h0000_003f);
      wr(LIMIT_ADDR, 32'hffff_ffff, 2'h2);
      rd_chk(LIMIT_ADDR, 32'h001f_003f);
      wr(32'h5000_4020, 32'hffff_ffff, 2'h3);
      rd_chk(32'h5000_4020, 32'h0);
      wr(LIMIT_ADDR, 32'h0, 2'h3);
   endtask : s_lanes

   // ------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      clk_sys   = 1'b0;
      rst       = 1'b1;
      addr      = '0;
      wr_data   = '0;
      wr_en     = 1'b0;
      wr_lanes  = 2'h3;
      rd_en     = 1'b0;
      event_in  = '0;
      match0_l  = 1'b0;
      match0_h  = 1'b0;
      err_count = 0;
      n_tests   = 0;
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      #1;
      s_reset();
      s_lanes();
      s_rate();
      s_stop();
      s_freeze();
      s_limit();
      s_join();
      s_auto();
      s_wrap();
      conclude();
   end

   // the wrap run dominates, about 66k cycles; limit sits near 90k cycles
   initial begin
      #450us;
      err_count++;
      conclude();
   end
endmodule : split_counter_limit_halt_control_tb
